// ==== design/tmt_tracker.v ====
`timescale 1ns/1ps
`default_nettype none
`include "tmt_defines.vh"

module tmt_tracker #(
   parameter [6:0] DEV_ADDR = `TMT_DEV_ADDR
) (
   input wire clock,
   input wire arst_n,
   input wire scl_in,
   input wire sda_in,
   output wire sda_out,
   output wire sda_oe_n,
   input wire sample_valid,
   input wire [11:0] sample_temp,
   output reg [11:0] temp_min,
   output reg [11:0] temp_max
);

   // ----------------------------------------
   // states
   // ----------------------------------------
   localparam [2:0] ST_IDLE = 3'h0;
   localparam [2:0] ST_ADDR = 3'h1;
   localparam [2:0] ST_ACK_A = 3'h2;
   localparam [2:0] ST_WDATA = 3'h3;
   localparam [2:0] ST_ACK_W = 3'h4;
   localparam [2:0] ST_RDATA = 3'h5;
   localparam [2:0] ST_ACK_R = 3'h6;

   function is_below;
      input [11:0] a;
      input [11:0] b;
      begin
         is_below = $signed(a) < $signed(b);
      end
   endfunction

   // ----------------------------------------
   // pin synchronisers and line filter
   // ----------------------------------------
   reg [2:0] scl_sync;
   reg [2:0] sda_sync;
   reg scl_f;
   reg sda_f;
   reg scl_q;
   reg sda_q;

   // a level counts only once stages two and three agree
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         scl_sync <= 3'h7;
         sda_sync <= 3'h7;
         scl_f <= 1'b1;
         sda_f <= 1'b1;
         scl_q <= 1'b1;
         sda_q <= 1'b1;
      end else begin
         scl_sync <= {scl_sync[1:0], scl_in};
         sda_sync <= {sda_sync[1:0], sda_in};
         if (scl_sync[1] == scl_sync[2]) begin
            scl_f <= scl_sync[2];
         end
         if (sda_sync[1] == sda_sync[2]) begin
            sda_f <= sda_sync[2];
         end
         scl_q <= scl_f;
         sda_q <= sda_f;
      end
   end

   wire scl_rise = scl_f & ~scl_q;
   wire scl_fall = ~scl_f & scl_q;
   wire bus_start = scl_f & scl_q & sda_q & ~sda_f;
   wire bus_stop = scl_f & scl_q & ~sda_q & sda_f;

   // ----------------------------------------
   // serial slave
   // ----------------------------------------
   reg [2:0] state;
   reg [3:0] bit_cnt;
   reg [7:0] rx_byte;
   reg [7:0] tx_byte;
   reg [7:0] ptr;
   reg ptr_phase;
   reg is_read;
   reg drive_low;
   reg wr_en;
   reg [7:0] wr_addr;
   reg [7:0] wr_data;
   reg [7:0] rd_data;

   // open drain: only ever pulls low
   assign sda_out = 1'b0;
   assign sda_oe_n = ~drive_low;

   always @* begin
      case (ptr)
         `TMT_OFS_LOW_HIGH: rd_data = temp_min[11:4];
         `TMT_OFS_LOW_LOW: rd_data = {temp_min[3:0], 4'h0};
         `TMT_OFS_HIGH_HIGH: rd_data = temp_max[11:4];
         `TMT_OFS_HIGH_LOW: rd_data = {temp_max[3:0], 4'h0};
         default: rd_data = 8'h00;
      endcase
   end

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         state <= ST_IDLE;
         bit_cnt <= 4'h0;
         rx_byte <= 8'h00;
         tx_byte <= 8'h00;
         ptr <= `TMT_PTR_RST;
         ptr_phase <= 1'b0;
         is_read <= 1'b0;
         drive_low <= 1'b0;
         wr_en <= 1'b0;
         wr_addr <= 8'h00;
         wr_data <= 8'h00;
      end else begin
         wr_en <= 1'b0;
         if (bus_start) begin
            state <= ST_ADDR;
            bit_cnt <= 4'h0;
            ptr_phase <= 1'b1;
            drive_low <= 1'b0;
         end else if (bus_stop) begin
            state <= ST_IDLE;
            drive_low <= 1'b0;
         end else begin
            case (state)
               ST_ADDR, ST_WDATA: begin
                  if (scl_rise) begin
                     rx_byte <= {rx_byte[6:0], sda_f};
                     bit_cnt <= bit_cnt + 4'h1;
                  end else if (scl_fall && bit_cnt == `TMT_BITS_PER_BYTE) begin
                     bit_cnt <= 4'h0;
                     if (state == ST_ADDR) begin
                        if (rx_byte[7:1] == DEV_ADDR) begin
                           drive_low <= 1'b1;
                           is_read <= rx_byte[0];
                           state <= ST_ACK_A;
                        end else begin
                           state <= ST_IDLE;
                        end
                     end else begin
                        drive_low <= 1'b1;
                        state <= ST_ACK_W;
                        if (ptr_phase) begin
                           ptr <= rx_byte;
                           ptr_phase <= 1'b0;
                        end else begin
                           wr_en <= 1'b1;
                           wr_addr <= ptr;
                           wr_data <= rx_byte;
                           ptr <= ptr + 8'h01;
                        end
                     end
                  end
               end
               ST_ACK_A, ST_ACK_R: begin
                  // master nack ends the read; wait for stop
                  if (state == ST_ACK_R && scl_rise && sda_f) begin
                     state <= ST_IDLE;
                  end else if (scl_fall) begin
                     if (is_read) begin
                        tx_byte <= {rd_data[6:0], 1'b0};
                        drive_low <= ~rd_data[7];
                        bit_cnt <= 4'h1;
                        state <= ST_RDATA;
                     end else begin
                        drive_low <= 1'b0;
                        state <= ST_WDATA;
                     end
                  end
               end
               ST_ACK_W: begin
                  if (scl_fall) begin
                     drive_low <= 1'b0;
                     state <= ST_WDATA;
                  end
               end
               ST_RDATA: begin
                  if (scl_fall) begin
                     if (bit_cnt == `TMT_BITS_PER_BYTE) begin
                        drive_low <= 1'b0;
                        ptr <= ptr + 8'h01;
                        state <= ST_ACK_R;
                     end else begin
                        drive_low <= ~tx_byte[7];
                        tx_byte <= {tx_byte[6:0], 1'b0};
                        bit_cnt <= bit_cnt + 4'h1;
                     end
                  end
               end
               default: begin
                  drive_low <= 1'b0;
               end
            endcase
         end
      end
   end

   // ----------------------------------------
   // extreme tracking
   // ----------------------------------------
   // an empty pair loads the next sample, otherwise a zero clear would pin it
   reg min_empty;
   reg max_empty;

   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         temp_min <= `TMT_TEMP_RST;
         temp_max <= `TMT_TEMP_RST;
         min_empty <= 1'b1;
         max_empty <= 1'b1;
      end else if (sample_valid) begin
         // a sample wins over a host write in the same cycle
         // capture lower and higher
         if (min_empty || is_below(sample_temp, temp_min)) begin
            temp_min <= sample_temp;
            min_empty <= 1'b0;
         end
         if (max_empty || is_below(temp_max, sample_temp)) begin
            temp_max <= sample_temp;
            max_empty <= 1'b0;
         end
      end else if (wr_en) begin
         // host write, zero pair restarts tracking
         case (wr_addr)
            `TMT_OFS_LOW_HIGH: begin
               temp_min[11:4] <= wr_data;
               min_empty <= (wr_data == 8'h00) && (temp_min[3:0] == 4'h0);
            end
            `TMT_OFS_LOW_LOW: begin
               temp_min[3:0] <= wr_data[`TMT_FRAC_HI:`TMT_FRAC_LO];
               min_empty <= (wr_data[7:4] == 4'h0) && (temp_min[11:4] == 8'h00);
            end
            `TMT_OFS_HIGH_HIGH: begin
               temp_max[11:4] <= wr_data;
               max_empty <= (wr_data == 8'h00) && (temp_max[3:0] == 4'h0);
            end
            `TMT_OFS_HIGH_LOW: begin
               temp_max[3:0] <= wr_data[`TMT_FRAC_HI:`TMT_FRAC_LO];
               max_empty <= (wr_data[7:4] == 4'h0) && (temp_max[11:4] == 8'h00);
            end
            default: begin
               min_empty <= min_empty;
            end
         endcase
      end
   end

endmodule // tmt_tracker

`default_nettype wire

// ==== design/tmt_defines.vh ====
// Function
// - keep lowest captured temperature in a register pair at 1Fh and 20h
// - keep highest captured temperature in a register pair at 24h and 25h
// - each extreme is a 12-bit two's-complement value in degrees Celsius
// - upper register holds eight integer bits; lower register bits 7..4 hold fraction
// - pairs reset to zero; host writing zero clears a pair and restarts tracking unless a sample lands in the same cycle and drops the write
`ifndef TMT_DEFINES_VH
`define TMT_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define TMT_OFS_LOW_HIGH 8'h1F
`define TMT_OFS_LOW_LOW 8'h20
`define TMT_OFS_HIGH_HIGH 8'h24
`define TMT_OFS_HIGH_LOW 8'h25

// ----------------------------------------
// field layout and reset values
// ----------------------------------------
`define TMT_TEMP_W 12
`define TMT_FRAC_HI 7
`define TMT_FRAC_LO 4
`define TMT_TEMP_RST 12'h000
`define TMT_PTR_RST 8'h00

// ----------------------------------------
// serial interface
// ----------------------------------------
// arbitrary value, not a real part's address
`define TMT_DEV_ADDR 7'h2A
`define TMT_BITS_PER_BYTE 4'h8

`endif

// ==== sim/tmt_tracker_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// extreme tracking checks
// ----------------------------------------
module tmt_tracker_checker (
   input wire logic clock,
   input wire logic arst_n,
   input wire logic sample_valid,
   input wire logic [11:0] sample_temp,
   input wire logic [11:0] temp_min,
   input wire logic [11:0] temp_max
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   a_reset_clear: assert property ($rose(arst_n) |-> temp_min == 12'h000
      && temp_max == 12'h000) else $error("extremes not zero after reset");
   a_min_lower: assert property (sample_valid
      && $signed(sample_temp) < $signed(temp_min)
      |=> temp_min == $past(sample_temp)) else $error("lower sample not kept");
   a_max_higher: assert property (sample_valid
      && $signed(sample_temp) > $signed(temp_max)
      |=> temp_max == $past(sample_temp)) else $error("higher sample not kept");
   // a zero pair may be empty and load anything, so only nonzero pairs must hold
   a_min_hold: assert property (sample_valid && temp_min != 12'h000
      && $signed(sample_temp) >= $signed(temp_min) |=> $stable(temp_min))
      else $error("minimum moved without a lower sample");
   a_max_hold: assert property (sample_valid && temp_max != 12'h000
      && $signed(sample_temp) <= $signed(temp_max) |=> $stable(temp_max))
      else $error("maximum moved without a higher sample");
   a_signed_min: assert property (sample_valid && sample_temp[11] && !temp_min[11]
      |=> temp_min == $past(sample_temp)) else $error("negative sample not below positive");
endmodule // tmt_tracker_checker
bind tmt_tracker tmt_tracker_checker chk_i (.clock(clock), .arst_n(arst_n),
   .sample_valid(sample_valid), .sample_temp(sample_temp), .temp_min(temp_min),
   .temp_max(temp_max));
`default_nettype wire

// ==== sim/tmt_host.sv ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// serial bus host
// ----------------------------------------
module tmt_host (
   input wire logic clock,
   input wire logic sda,
   output logic scl,
   output logic sda_drv
);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge clock);
   endtask
   // start is cond(1,0), stop is cond(0,1); 8 clocks keeps clear of the slave filter
   task automatic cond(input logic a, input logic b);
      tick(8);
      sda_drv <= a;
      tick(8);
      scl <= 1'b1;
      tick(8);
      sda_drv <= b;
      tick(8);
      scl <= b;
   endtask
   // long low phase: slave answers about 5 clocks after scl falls
   task automatic bit_io(input logic b, output logic r);
      tick(8);
      sda_drv <= b;
      tick(8);
      scl <= 1'b1;
      tick(8);
      r = sda;
      scl <= 1'b0;
   endtask
   // host shifts a byte out msb first and reads sda back, then sends or reads the ack bit
   task automatic xfer(input logic [7:0] w, input logic last, output logic [7:0] r,
      output logic ack);
      logic x;
      for (int i = 7; i >= 0; i--) begin
         bit_io(w[i], x);
         r[i] = x;
      end
      bit_io(last, ack);
   endtask
endmodule // tmt_host
`default_nettype wire

// ==== sim/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "tmt_defines.vh"
// ----------------------------------------
// tracker bench
// ----------------------------------------
module tb_top;
   logic clock = 1'b0;
   logic arst_n = 1'b0;
   logic sample_valid = 1'b0;
   logic [11:0] sample_temp = 12'h000;
   logic [11:0] temp_min, temp_max, emin, emax;
   logic [7:0] d, d2;
   logic ack, mn_e, mx_e, scl, h_sda, sda_out, sda_oe_n;
   wire sda_w;
   int miscompares = 0;
   int compares = 0;
   int cycles = 0;
   assign sda_w = h_sda & (sda_oe_n | sda_out);
   initial forever #50 clock = ~clock;
   tmt_host host (.clock(clock), .sda(sda_w), .scl(scl), .sda_drv(h_sda));
   tmt_tracker dut (.clock(clock), .arst_n(arst_n), .scl_in(scl), .sda_in(sda_w),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .sample_valid(sample_valid),
      .sample_temp(sample_temp), .temp_min(temp_min), .temp_max(temp_max));
   task chk(input logic [11:0] seen, input logic [11:0] exp);
      compares++;
      if (seen !== exp) begin
         miscompares++;
         $display("Error %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task close_out();
      if (miscompares == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // a frame for a foreign address is never acknowledged
   task wr(input logic [6:0] dev, input logic [7:0] a, input logic [7:0] v);
      host.cond(1'b1, 1'b0);
      host.xfer({dev, 1'b0}, 1'b1, d, ack);
      chk({11'h000, ack}, {11'h000, dev != `TMT_DEV_ADDR});
      host.xfer(a, 1'b1, d, ack);
      chk({11'h000, ack}, {11'h000, dev != `TMT_DEV_ADDR});
      host.xfer(v, 1'b1, d, ack);
      chk({11'h000, ack}, {11'h000, dev != `TMT_DEV_ADDR});
      host.cond(1'b0, 1'b1);
   endtask
   // two bytes: master ack asks for the next register, nack ends the read
   task rd(input logic [7:0] a);
      host.cond(1'b1, 1'b0);
      host.xfer({`TMT_DEV_ADDR, 1'b0}, 1'b1, d, ack);
      chk({11'h000, ack}, 12'h000);
      host.xfer(a, 1'b1, d, ack);
      chk({11'h000, ack}, 12'h000);
      host.cond(1'b1, 1'b0);
      host.xfer({`TMT_DEV_ADDR, 1'b1}, 1'b1, d, ack);
      chk({11'h000, ack}, 12'h000);
      host.xfer(8'hFF, 1'b0, d, ack);
      host.xfer(8'hFF, 1'b1, d2, ack);
      host.cond(1'b0, 1'b1);
   endtask
   // expected pair: an empty pair loads the first sample whatever it is
   function automatic logic [11:0] lower_of(input logic empty, input logic [11:0] v,
      input logic [11:0] old);
      return (empty || $signed(v) < $signed(old)) ? v : old;
   endfunction
   function automatic logic [11:0] higher_of(input logic empty, input logic [11:0] v,
      input logic [11:0] old);
      return (empty || $signed(v) > $signed(old)) ? v : old;
   endfunction
   task samp(input logic [11:0] v);
      @(posedge clock);
      sample_valid <= 1'b1;
      sample_temp <= v;
      emin = lower_of(mn_e, v, emin);
      emax = higher_of(mx_e, v, emax);
      mn_e = 1'b0;
      mx_e = 1'b0;
   endtask
   task idle();
      @(posedge clock);
      sample_valid <= 1'b0;
      @(posedge clock);
      @(negedge clock);
   endtask
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 30000) begin
         miscompares++;
         close_out();
      end
   end
   initial begin
      {mn_e, mx_e, emin, emax} = {2'b11, 24'h000000};
      d = 8'($urandom(31162));
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      repeat (4) @(posedge clock);
      @(negedge clock);
      chk(temp_min, 12'h000);
      chk(temp_max, 12'h000);
      samp(12'hFB0);
      repeat (20) samp(12'($urandom));
      idle();
      chk(temp_min, emin);
      chk(temp_max, emax);
      rd(`TMT_OFS_LOW_HIGH);
      chk({4'h0, d}, {4'h0, emin[11:4]});
      chk({4'h0, d2}, {4'h0, emin[3:0], 4'h0});
      rd(`TMT_OFS_LOW_LOW);
      chk({4'h0, d}, {4'h0, emin[3:0], 4'h0});
      chk({4'h0, d2}, 12'h000);
      rd(`TMT_OFS_HIGH_HIGH);
      chk({4'h0, d}, {4'h0, emax[11:4]});
      chk({4'h0, d2}, {4'h0, emax[3:0], 4'h0});
      rd(`TMT_OFS_HIGH_LOW);
      chk({4'h0, d}, {4'h0, emax[3:0], 4'h0});
      chk({4'h0, d2}, 12'h000);
      wr(`TMT_DEV_ADDR, `TMT_OFS_LOW_HIGH, 8'h00);
      wr(`TMT_DEV_ADDR, `TMT_OFS_LOW_LOW, 8'h00);
      chk(temp_min, 12'h000);
      mn_e = 1'b1;
      samp(12'h800);
      samp(12'h7FF);
      idle();
      chk(temp_min, emin);
      chk(temp_max, emax);
      // a clear sent to another address must leave the pair alone
      wr(`TMT_DEV_ADDR ^ 7'h01, `TMT_OFS_LOW_HIGH, 8'h00);
      chk(temp_min, emin);
      wr(`TMT_DEV_ADDR, `TMT_OFS_HIGH_HIGH, 8'h10);
      wr(`TMT_DEV_ADDR, `TMT_OFS_HIGH_LOW, 8'hFF);
      emax = 12'h10F;
      chk(temp_max, emax);
      rd(`TMT_OFS_HIGH_LOW);
      chk({4'h0, d}, 12'h0F0);
      chk({4'h0, d2}, 12'h000);
      samp(12'h100);
      idle();
      chk(temp_max, emax);
      // reset in mid-run empties both pairs, so a negative sample loads the maximum
      @(posedge clock);
      arst_n <= 1'b0;
      repeat (4) @(posedge clock);
      arst_n <= 1'b1;
      repeat (4) @(posedge clock);
      @(negedge clock);
      chk(temp_min, 12'h000);
      chk(temp_max, 12'h000);
      {mn_e, mx_e} = 2'b11;
      samp(12'hFF0);
      idle();
      chk(temp_min, emin);
      chk(temp_max, emax);
      close_out();
   end
endmodule // tb_top
`default_nettype wire
